// *** design/urs_channel_regs.sv ***
// One channel's register select, access gating and receive holding queue
//
// How it works
// - Three address bits plus register bits select location
// - Location 0 reads receive queue, writes transmit
// - Location 1 holds interrupt enable, read/write
// - Location 2 reads identification, writes queue control
// - Location 3 always reaches line format control
// - Location 4 reaches modem control without key
// - Location 5 reads line state, ignores writes
// - Location 6 reads modem state, ignores writes
// - Divisor bytes overlay 0,1 when bit 7 set
// - Alternate function at 2 when top bits 100
// - Key value maps enhanced and flow characters
// - Threshold/trigger need enhanced and modem bit 6
// - Ready register needs select, enable, no loopback
// - Prescaler bit writable only when enhanced enabled
// - Enhanced bits change only when enhanced enabled
// - Receive queue holds 64 characters for reads
// - Queue off: only first entry used
// - Full queue discards new characters unless a data read pops in the same cycle
// - Error flags stored beside each character
// - Receiver framing comes from line format control
// - Line state read never advances read pointer
module urs_channel_regs
(
    input  wire logic                    clk,
    input  wire logic                    rst_b,
    input  wire urs_pkg::urs_host_req_t  host_req,
    input  wire logic                    any_cs_b,
    input  wire logic [7:0]              queue_ready_all,
    input  wire logic [7:0]              line_state_ext,
    input  wire logic [7:0]              modem_state_ext,
    input  wire logic                    rx_char_valid,
    input  wire urs_pkg::urs_rx_char_t   rx_char,
    output logic [7:0]                   rdata,
    output logic                         tx_load,
    output logic [7:0]                   tx_data,
    output urs_pkg::urs_frame_cfg_t      frame_cfg,
    output logic [15:0]                  baud_divisor,
    output logic [7:0]                   alt_func,
    output logic [7:0]                   rx_level
);
    typedef struct packed {
        logic [7:0]           ien;
        logic [7:0]           qc;
        logic [7:0]           lfc;
        logic [7:0]           mlc;
        logic [7:0]           scr;
        logic [7:0]           dll;
        logic [7:0]           baud_divisor_high;
        logic [7:0]           alternate_function;
        logic [7:0]           enhanced_feature;
        logic [7:0]           on1;
        logic [7:0]           on2;
        logic [7:0]           off1;
        logic [7:0]           off2;
        logic [7:0]           flow_threshold_control;
        logic [7:0]           queue_trigger_levels;
        logic [urs_pkg::PTR_W-1:0] rptr;
        logic [urs_pkg::PTR_W-1:0] wptr;
        logic [6:0]           cnt;
        logic [7:0]           rdata;
        logic                 tx_load;
        logic [7:0]           tx_data;
    } urs_state_t;

    urs_state_t state_q;
    urs_state_t state_d;
    logic       rst_meta_q;
    logic       rst_sync_q;
    logic       rst_sync_b;

    // Receive queue storage; no reset needed, only pointers matter
    urs_pkg::urs_rx_char_t rxq_mem [urs_pkg::FIFO_DEPTH];

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end
    assign rst_sync_b = rst_sync_q;

    ////////////////////////////////////////////////////////////////////////
    // Selection qualifiers
    logic       key_sel;
    logic       div_sel;
    logic       alt_sel;
    logic       enh_on;
    logic       thr_sel;
    logic       rdy_sel;
    logic       fifo_on;
    logic       rx_full;
    logic       rx_push;
    logic       rx_pop;
    logic       err_any;
    logic [2:0] a;
    logic [7:0] wd;
    urs_pkg::urs_rx_char_t head;

    always_comb
    begin
        a       = host_req.addr;
        wd      = host_req.wdata;
        key_sel = (state_q.lfc == urs_pkg::LFC_ENH_KEY);
        div_sel = state_q.lfc[urs_pkg::LFC_DIV_BIT];
        alt_sel = (state_q.lfc[7:5] == urs_pkg::LFC_ALT_KEY);
        enh_on  = state_q.enhanced_feature[urs_pkg::EFR_ENH_BIT];
        thr_sel = enh_on && state_q.mlc[urs_pkg::MLC_TCR_BIT];
        rdy_sel = !any_cs_b && state_q.mlc[urs_pkg::MLC_RDY_BIT]
                  && !state_q.mlc[urs_pkg::MLC_LOOP_BIT];
        fifo_on = state_q.qc[urs_pkg::QC_EN_BIT];
        // Queue off: capacity of one, slot zero
        rx_full = fifo_on ? (state_q.cnt == 7'(urs_pkg::FIFO_DEPTH))
                          : (state_q.cnt != urs_pkg::CNT_RST);
        head    = rxq_mem[state_q.rptr];
        // Only a data read with no divisor overlay pops
        rx_pop  = host_req.rd && (a == urs_pkg::ADDR_DATA) && !div_sel
                  && (state_q.cnt != urs_pkg::CNT_RST);
        rx_push = rx_char_valid && (!rx_full || rx_pop);
    end

    // Error summary across all stored characters, recomputed every cycle
    always_comb
    begin
        err_any = 1'b0;
        for (int i = 0; i < urs_pkg::FIFO_DEPTH; i++)
        begin
            if ((6'(i - int'(state_q.rptr)) < state_q.cnt[5:0] || state_q.cnt[6])
                && (rxq_mem[i].brk || rxq_mem[i].frm || rxq_mem[i].par))
            begin
                err_any = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb
    begin
        state_d         = state_q;
        state_d.tx_load = 1'b0;
        // Read mux, decided by address then overlays
        if (a == urs_pkg::ADDR_DATA)
        begin
            state_d.rdata = div_sel ? state_q.dll : head.data;
        end
        else if (a == urs_pkg::ADDR_IEN)
        begin
            state_d.rdata = div_sel ? state_q.baud_divisor_high : state_q.ien;
        end
        else if (a == urs_pkg::ADDR_IDQC)
        begin
            if (key_sel)
                state_d.rdata = state_q.enhanced_feature;
            else if (alt_sel)
                state_d.rdata = state_q.alternate_function;
            else
                state_d.rdata = {{2{fifo_on}}, 5'h00, 1'b1};
        end
        else if (a == urs_pkg::ADDR_LFC)
        begin
            state_d.rdata = state_q.lfc;
        end
        else if (a == urs_pkg::ADDR_MLC)
        begin
            state_d.rdata = key_sel ? state_q.on1 : state_q.mlc;
        end
        else if (a == urs_pkg::ADDR_LST)
        begin
            // Break, framing and parity bits come from the head character, not a stored copy; bit 7 sums all stored characters
            state_d.rdata = key_sel ? state_q.on2
                          : {err_any, line_state_ext[6:5], head.brk, head.frm,
                             head.par, line_state_ext[1],
                             state_q.cnt != urs_pkg::CNT_RST};
        end
        else if (a == urs_pkg::ADDR_MLS)
        begin
            if (key_sel)
                state_d.rdata = state_q.off1;
            else if (thr_sel)
                state_d.rdata = state_q.flow_threshold_control;
            else
                state_d.rdata = modem_state_ext;
        end
        else
        begin
            if (key_sel)
                state_d.rdata = state_q.off2;
            else if (rdy_sel)
                state_d.rdata = queue_ready_all;
            else if (thr_sel)
                state_d.rdata = state_q.queue_trigger_levels;
            else
                state_d.rdata = state_q.scr;
        end
        if (!host_req.rd)
            state_d.rdata = state_q.rdata;

        // Clear pulse bits of queue control never stick
        state_d.qc[urs_pkg::QC_RXCLR_BIT] = 1'b0;
        state_d.qc[2] = 1'b0;
        if (host_req.wr)
        begin
            if (a == urs_pkg::ADDR_DATA)
            begin
                if (div_sel)
                    state_d.dll = wd;
                else
                begin
                    state_d.tx_load = 1'b1;
                    state_d.tx_data = wd;
                end
            end
            else if (a == urs_pkg::ADDR_IEN)
            begin
                if (div_sel)
                    state_d.baud_divisor_high = wd;
                else
                    state_d.ien = enh_on ? wd : ((wd & ~urs_pkg::IEN_ENH_MASK)
                                  | (state_q.ien & urs_pkg::IEN_ENH_MASK));
            end
            else if (a == urs_pkg::ADDR_IDQC)
            begin
                if (key_sel)
                    state_d.enhanced_feature = wd;
                else if (alt_sel)
                    state_d.alternate_function = wd;
                else
                    state_d.qc = enh_on ? wd : ((wd & ~urs_pkg::QC_ENH_MASK)
                                 | (state_q.qc & urs_pkg::QC_ENH_MASK));
            end
            else if (a == urs_pkg::ADDR_LFC)
            begin
                state_d.lfc = wd;
            end
            else if (a == urs_pkg::ADDR_MLC)
            begin
                if (key_sel)
                    state_d.on1 = wd;
                else
                    state_d.mlc = enh_on ? wd : ((wd & ~urs_pkg::MLC_ENH_MASK)
                                  | (state_q.mlc & urs_pkg::MLC_ENH_MASK));
            end
            else if (a == urs_pkg::ADDR_LST)
            begin
                if (key_sel)
                    state_d.on2 = wd;
            end
            else if (a == urs_pkg::ADDR_MLS)
            begin
                if (key_sel)
                    state_d.off1 = wd;
                else if (thr_sel)
                    state_d.flow_threshold_control = wd;
            end
            else
            begin
                if (key_sel)
                    state_d.off2 = wd;
                else if (thr_sel && !rdy_sel)
                    state_d.queue_trigger_levels = wd;
                else if (!rdy_sel)
                    state_d.scr = wd;
            end
        end

        // Queue pointers; a clear request or mode change empties it
        if (rx_pop)
            state_d.rptr = fifo_on ? state_q.rptr + 6'h01 : 6'h00;
        if (rx_push)
            state_d.wptr = fifo_on ? state_q.wptr + 6'h01 : 6'h00;
        state_d.cnt = state_q.cnt + 7'(rx_push) - 7'(rx_pop);
        if (host_req.wr && a == urs_pkg::ADDR_IDQC && !key_sel && !alt_sel
            && (wd[urs_pkg::QC_RXCLR_BIT]
                || wd[urs_pkg::QC_EN_BIT] != state_q.qc[urs_pkg::QC_EN_BIT]))
        begin
            state_d.rptr = 6'h00;
            state_d.wptr = 6'h00;
            state_d.cnt  = urs_pkg::CNT_RST;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_b)
    begin
        if (!rst_sync_b)
            state_q <= '0;
        else
            state_q <= state_d;
    end

    // Character and flags stored together
    always_ff @(posedge clk)
    begin
        if (rx_push)
            rxq_mem[fifo_on ? state_q.wptr : 6'h00] <= rx_char;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign rdata        = state_q.rdata;
    assign tx_load      = state_q.tx_load;
    assign tx_data      = state_q.tx_data;
    assign baud_divisor = {state_q.baud_divisor_high, state_q.dll};
    assign alt_func     = state_q.alternate_function;
    assign rx_level     = {1'b0, state_q.cnt};
    always_comb
    begin
        frame_cfg.word_len  = state_q.lfc[1:0];
        frame_cfg.stop2     = state_q.lfc[2];
        frame_cfg.par_en    = state_q.lfc[3];
        frame_cfg.par_even  = state_q.lfc[4];
        frame_cfg.par_force = state_q.lfc[5];
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    property p_lfc_always;
        @(posedge clk) disable iff (!rst_sync_b)
        host_req.wr && a == urs_pkg::ADDR_LFC |=> state_q.lfc == $past(wd);
    endproperty
    a_lfc_always: assert property (p_lfc_always) else $error("lfc write lost");

    property p_presc_lock;
        @(posedge clk) disable iff (!rst_sync_b)
        !enh_on |=> $stable(state_q.mlc[urs_pkg::MLC_PRESC_BIT]);
    endproperty
    a_presc_lock: assert property (p_presc_lock) else $error("prescaler changed");

    property p_ien_lock;
        @(posedge clk) disable iff (!rst_sync_b)
        !enh_on |=> state_q.ien[7:4] == $past(state_q.ien[7:4]);
    endproperty
    a_ien_lock: assert property (p_ien_lock) else $error("enhanced bits changed");

    property p_no_overflow;
        @(posedge clk) disable iff (!rst_sync_b)
        state_q.cnt <= 7'(urs_pkg::FIFO_DEPTH);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("queue overflow");

    property p_single_slot;
        @(posedge clk) disable iff (!rst_sync_b)
        !fifo_on |-> state_q.cnt <= 7'h01;
    endproperty
    a_single_slot: assert property (p_single_slot) else $error("slot count");

    property p_lst_no_pop;
        @(posedge clk) disable iff (!rst_sync_b)
        host_req.rd && a == urs_pkg::ADDR_LST && !rx_char_valid && !host_req.wr
        |=> $stable(state_q.rptr);
    endproperty
    a_lst_no_pop: assert property (p_lst_no_pop) else $error("pointer moved");

    property p_tx_load;
        @(posedge clk) disable iff (!rst_sync_b)
        host_req.wr && a == urs_pkg::ADDR_DATA && !div_sel
        |=> (tx_load && tx_data == $past(wd)) ##1 (!tx_load || $past(host_req.wr));
    endproperty
    a_tx_load: assert property (p_tx_load) else $error("tx load wrong");

    property p_key_efr;
        @(posedge clk) disable iff (!rst_sync_b)
        host_req.rd && a == urs_pkg::ADDR_IDQC && key_sel |=> rdata == $past(state_q.enhanced_feature);
    endproperty
    a_key_efr: assert property (p_key_efr) else $error("enhanced read wrong");

    property p_rdy_read;
        @(posedge clk) disable iff (!rst_sync_b)
        host_req.rd && a == urs_pkg::ADDR_SCR && !key_sel && rdy_sel
        |=> rdata == $past(queue_ready_all);
    endproperty
    a_rdy_read: assert property (p_rdy_read) else $error("ready read wrong");

    c_fill:   cover property (@(posedge clk) state_q.cnt == 7'(urs_pkg::FIFO_DEPTH));
    c_key:    cover property (@(posedge clk) key_sel && host_req.wr);
    c_thr:    cover property (@(posedge clk) thr_sel && host_req.rd && a == urs_pkg::ADDR_MLS);
    c_div:    cover property (@(posedge clk) div_sel && host_req.wr && a == urs_pkg::ADDR_IEN);
endmodule

// *** design/urs_pkg.sv ***
// Package for the channel register select block: offsets, fields, reset values, types
package urs_pkg;
    localparam logic [2:0] ADDR_DATA     = 3'h0;
    localparam logic [2:0] ADDR_IEN      = 3'h1;
    localparam logic [2:0] ADDR_IDQC     = 3'h2;
    localparam logic [2:0] ADDR_LFC      = 3'h3;
    localparam logic [2:0] ADDR_MLC      = 3'h4;
    localparam logic [2:0] ADDR_LST      = 3'h5;
    localparam logic [2:0] ADDR_MLS      = 3'h6;
    localparam logic [2:0] ADDR_SCR      = 3'h7;
    localparam logic [7:0] LFC_ENH_KEY   = 8'hbf;
    localparam logic [2:0] LFC_ALT_KEY   = 3'h4;
    localparam int         LFC_DIV_BIT   = 7;
    localparam int         MLC_PRESC_BIT = 7;
    localparam int         MLC_TCR_BIT   = 6;
    localparam int         MLC_LOOP_BIT  = 4;
    localparam int         MLC_RDY_BIT   = 2;
    localparam int         EFR_ENH_BIT   = 4;
    localparam int         QC_EN_BIT     = 0;
    localparam int         QC_RXCLR_BIT  = 1;
    localparam logic [7:0] QC_ENH_MASK   = 8'h30;
    localparam logic [7:0] IEN_ENH_MASK  = 8'hf0;
    localparam logic [7:0] MLC_ENH_MASK  = 8'he0;
    localparam logic [7:0] REG_RST       = 8'h00;
    localparam logic [7:0] IID_NONE      = 8'h01;
    localparam int         FIFO_DEPTH    = 64;
    localparam int         PTR_W         = 6;
    localparam logic [6:0] CNT_RST       = 7'h00;

    typedef struct packed {
        logic       brk;
        logic       frm;
        logic       par;
        logic [7:0] data;
    } urs_rx_char_t;

    typedef struct packed {
        logic [2:0] addr;
        logic       rd;
        logic       wr;
        logic [7:0] wdata;
    } urs_host_req_t;

    typedef struct packed {
        logic [1:0] word_len;
        logic       stop2;
        logic       par_en;
        logic       par_even;
        logic       par_force;
    } urs_frame_cfg_t;
endpackage

// *** testbench/tb_top.sv ***
// Self-checking bench for the channel register select block
`define CHK(nm, e, g) \
    begin \
        n_compared++; \
        if ((g) !== (e)) \
        begin \
            miscompares++; \
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
        end \
    end

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                   clk;
    logic                   rst_b;
    urs_pkg::urs_host_req_t host_req;
    logic                   any_cs_b;
    logic [7:0]             queue_ready_all;
    logic [7:0]             line_state_ext;
    logic [7:0]             modem_state_ext;
    logic                   rx_char_valid;
    urs_pkg::urs_rx_char_t  rx_char;
    logic [7:0]             rdata;
    logic                   tx_load;
    logic [7:0]             tx_data;
    urs_pkg::urs_frame_cfg_t frame_cfg;
    logic [15:0]            baud_divisor;
    logic [7:0]             alt_func;
    logic [7:0]             rx_level;
    logic                   rd_p;
    logic [7:0]             exp_b;
    int                     seed = 74;
    int                     cycles = 0;
    int                     miscompares = 0;
    int                     n_compared = 0;

    urs_host_model u_host (.clk(clk), .host_req(host_req));

    urs_channel_regs DUT
    (
        .clk(clk), .rst_b(rst_b), .host_req(host_req), .any_cs_b(any_cs_b),
        .queue_ready_all(queue_ready_all), .line_state_ext(line_state_ext),
        .modem_state_ext(modem_state_ext), .rx_char_valid(rx_char_valid),
        .rx_char(rx_char), .rdata(rdata), .tx_load(tx_load), .tx_data(tx_data),
        .frame_cfg(frame_cfg), .baud_divisor(baud_divisor), .alt_func(alt_func),
        .rx_level(rx_level)
    );

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic complete_run();
        if (miscompares == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // A hang ends the run as a failure rather than stalling it
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            miscompares++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Monitor: read data lands one cycle after the strobe
    always @(posedge clk)
        rd_p <= host_req.rd;

    always @(negedge clk)
    begin
        if (rd_p === 1'b1)
        begin
            exp_b = u_host.rd_exp_q.pop_front();
            `CHK("rdata", exp_b, rdata)
        end
        if (tx_load === 1'b1)
        begin
            // A load nobody asked for shows up as a mismatch
            exp_b = (u_host.tx_exp_q.size() > 0) ? u_host.tx_exp_q.pop_front() : ~tx_data;
            `CHK("tx_data", exp_b, tx_data)
        end
    end

    task automatic push_char(input urs_pkg::urs_rx_char_t c);
        @(posedge clk);
        rx_char       <= c;
        rx_char_valid <= 1'b1;
        @(posedge clk);
        rx_char_valid <= 1'b0;
        rx_char       <= ~c;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        logic [7:0]            v;
        urs_pkg::urs_rx_char_t c [3];
        rst_b = 1'b0;
        rx_char_valid = 1'b0;
        rx_char = '0;
        any_cs_b = 1'b1;
        queue_ready_all = 8'($random(seed));
        line_state_ext = 8'h60;
        modem_state_ext = 8'($random(seed));
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        u_host.rd_reg(3'h3, 8'h00);
        u_host.rd_reg(3'h1, 8'h00);
        u_host.rd_reg(3'h4, 8'h00);
        repeat (4)
        begin
            v = 8'($random(seed)) & 8'h7f;
            u_host.wr_reg(3'h3, v);
            u_host.rd_reg(3'h3, v);
            @(negedge clk);
            `CHK("frame_cfg", {v[1:0], v[2], v[3], v[4], v[5]}, frame_cfg)
        end
        // Enhanced bits stay locked until the enhanced enable is set
        u_host.wr_reg(3'h3, 8'h00);
        u_host.wr_reg(3'h1, 8'hff);
        u_host.rd_reg(3'h1, 8'h0f);
        u_host.wr_reg(3'h4, 8'hff);
        u_host.rd_reg(3'h4, 8'h1f);
        u_host.wr_reg(3'h4, 8'h00);
        v = 8'($random(seed));
        u_host.tx_exp_q.push_back(v);
        u_host.wr_reg(3'h0, v);
        u_host.wr_reg(3'h5, 8'hff);
        u_host.wr_reg(3'h6, 8'hff);
        u_host.rd_reg(3'h6, modem_state_ext);
        u_host.wr_reg(3'h7, 8'h3c);
        u_host.rd_reg(3'h7, 8'h3c);
        // Divisor and alternate function overlays
        u_host.wr_reg(3'h3, 8'h80);
        u_host.wr_reg(3'h0, 8'h34);
        u_host.wr_reg(3'h1, 8'h12);
        u_host.wr_reg(3'h2, 8'ha5);
        u_host.rd_reg(3'h0, 8'h34);
        u_host.rd_reg(3'h1, 8'h12);
        u_host.rd_reg(3'h2, 8'ha5);
        @(negedge clk);
        `CHK("baud_divisor", 16'h1234, baud_divisor)
        `CHK("alt_func", 8'ha5, alt_func)
        u_host.wr_reg(3'h3, 8'h00);
        u_host.rd_reg(3'h1, 8'h0f);
        // Key value: enhanced feature and flow characters
        u_host.wr_reg(3'h3, 8'hbf);
        u_host.wr_reg(3'h2, 8'h10);
        for (int i = 4; i < 8; i++)
            u_host.wr_reg(3'(i), 8'(8'h40 + i));
        for (int i = 4; i < 8; i++)
            u_host.rd_reg(3'(i), 8'(8'h40 + i));
        u_host.rd_reg(3'h2, 8'h10);
        u_host.wr_reg(3'h3, 8'h03);
        u_host.wr_reg(3'h4, 8'hc0);
        u_host.rd_reg(3'h4, 8'hc0);
        u_host.wr_reg(3'h6, 8'h44);
        u_host.wr_reg(3'h7, 8'h55);
        u_host.rd_reg(3'h6, 8'h44);
        u_host.rd_reg(3'h7, 8'h55);
        // Location 7 priority among the overlays
        any_cs_b <= 1'b0;
        u_host.wr_reg(3'h4, 8'hc4);
        u_host.rd_reg(3'h7, queue_ready_all);
        u_host.wr_reg(3'h4, 8'hd4);
        u_host.rd_reg(3'h7, 8'h55);
        u_host.wr_reg(3'h4, 8'h80);
        u_host.rd_reg(3'h7, 8'h3c);
        u_host.rd_reg(3'h6, modem_state_ext);
        u_host.wr_reg(3'h4, 8'h84);
        u_host.wr_reg(3'h3, 8'hbf);
        u_host.rd_reg(3'h7, 8'h47);
        u_host.wr_reg(3'h3, 8'h03);
        any_cs_b <= 1'b1;
        // Receive queue with error flags
        u_host.wr_reg(3'h2, 8'h01);
        u_host.rd_reg(3'h2, 8'hc1);
        for (int i = 0; i < 3; i++)
        begin
            c[i] = urs_pkg::urs_rx_char_t'(11'($random(seed)));
            push_char(c[i]);
        end
        @(negedge clk);
        `CHK("rx_level", 8'h03, rx_level)
        v = {|{c[0][10:8], c[1][10:8], c[2][10:8]}, 2'b11, c[0][10:8], 2'b01};
        u_host.rd_reg(3'h5, v);
        u_host.rd_reg(3'h5, v);
        for (int i = 0; i < 3; i++)
            u_host.rd_reg(3'h0, c[i].data);
        // Overfill: the 65th character is dropped
        for (int i = 0; i < 65; i++)
            push_char(urs_pkg::urs_rx_char_t'(11'(i)));
        @(negedge clk);
        `CHK("rx_level", 8'h40, rx_level)
        u_host.rd_reg(3'h0, 8'h00);
        u_host.rd_reg(3'h0, 8'h01);
        // Clear pulse empties the queue without leaving queue mode
        u_host.wr_reg(3'h2, 8'h03);
        @(negedge clk);
        `CHK("rx_level", 8'h00, rx_level)
        // Queue off: single holding entry
        u_host.wr_reg(3'h2, 8'h00);
        push_char(11'h0a5);
        push_char(11'h05a);
        @(negedge clk);
        `CHK("rx_level", 8'h01, rx_level)
        u_host.rd_reg(3'h0, 8'ha5);
        repeat (4) @(posedge clk);
        // A strobe that never answered leaves its note behind
        `CHK("tx_pending", 0, u_host.tx_exp_q.size())
        `CHK("rd_pending", 0, u_host.rd_exp_q.size())
        complete_run();
    end
endmodule

// *** testbench/urs_host_model.sv ***
// Host bus model for the channel register select block
module urs_host_model
(
    input  wire logic              clk,
    output urs_pkg::urs_host_req_t host_req
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] rd_exp_q[$];
    logic [7:0] tx_exp_q[$];

    initial
    begin
        host_req = '0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One strobe per access; the idle edge between accesses keeps pulses apart
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        host_req.addr  <= a;
        host_req.wdata <= d;
        host_req.wr    <= 1'b1;
        @(posedge clk);
        host_req.wr    <= 1'b0;
        // Released data lines show the inverse, never a stale copy
        host_req.wdata <= ~d;
    endtask

    task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        host_req.addr <= a;
        host_req.rd   <= 1'b1;
        rd_exp_q.push_back(e);
        @(posedge clk);
        host_req.rd   <= 1'b0;
    endtask
endmodule
